// [rtl/aspm_err_class.sv]
// error classification and sticky basic/advanced error status
module aspm_err_class (
   // clock and reset
   input  wire logic                         sys_clk_in,
   input  wire logic                         rst_in,
   // detected errors and software controls
   input  wire logic [aspm_pkg::ERR_W-1:0]   err_in,
   input  wire logic [aspm_pkg::ERR_W-1:0]   sev_wr_in,
   input  wire logic                         sev_wr_en_in,
   input  wire logic [aspm_pkg::ERR_W-1:0]   status_clr_in,
   input  wire logic                         class_clr_in,
   // reporting
   output aspm_pkg::aspm_err_t               msg_out,
   output aspm_pkg::aspm_err_t               detected_out,
   output logic      [aspm_pkg::ERR_W-1:0]   status_out
);
   logic [aspm_pkg::ERR_W-1:0] sev_reg, sev_next, stat_reg, stat_next;
   aspm_pkg::aspm_err_t        msg_reg, msg_next, det_reg, det_next;
   logic [aspm_pkg::ERR_W-1:0] unc;

   always_comb begin
      unc       = err_in & ~aspm_pkg::ERR_COR_MASK;
      sev_next  = sev_wr_en_in ? sev_wr_in : sev_reg;
      // new errors win over a clear in the same cycle
      stat_next = (stat_reg & ~status_clr_in) | err_in;
      msg_next.cor      = |(err_in & aspm_pkg::ERR_COR_MASK);
      msg_next.nonfatal = |(unc & ~sev_reg);
      msg_next.fatal    = |(unc & sev_reg);
      det_next = class_clr_in ? msg_next : (det_reg | msg_next);
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sev_reg  <= aspm_pkg::ERR_SEV_RST;
         stat_reg <= '0;
         msg_reg  <= '0;
         det_reg  <= '0;
      end else begin
         sev_reg  <= sev_next;
         stat_reg <= stat_next;
         msg_reg  <= msg_next;
         det_reg  <= det_next;
      end
   end

   assign msg_out      = msg_reg;
   assign detected_out = det_reg;
   assign status_out   = stat_reg;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   cor_class_a: assert property ((|(err_in & aspm_pkg::ERR_COR_MASK)) |=> msg_out.cor)
      else $error("correctable error not reported");
   fatal_class_a: assert property ((|(err_in & ~aspm_pkg::ERR_COR_MASK & sev_reg))
      |=> msg_out.fatal)
      else $error("fatal error not reported");
   status_sticky_a: assert property ((|err_in)
      |=> (status_out & $past(err_in)) == $past(err_in))
      else $error("advanced status lost an error");
endmodule

// [rtl/aspm_link_pm.sv]
// active state link power control with latency reporting and error classes
// Behaviour
// - after software enables it, hardware enters and leaves low power on its own
// - in L0s only the transmitter idles; the receive path stays active
// - L1 is entered jointly; no receive until Recovery, no send until back in L0
// - L0s exit latency is computed from fast training count and held
// - two L0s and two L1 latencies; report the one matching common clock
// - report whether the slot reference clock is used
// - in L1 command the phy into P1
// - leaving L1, wait transmit pll lock, go to Recovery, then L0
// - own L1 exit latency is held and reported; software combines ends
// - L0s and L1 acceptable latencies are held and reported
// - keep both basic and advanced error status
// - each error is reported as correctable, non-fatal or fatal
module aspm_link_pm (
   // clock and reset
   input  wire logic                         sys_clk_in,
   input  wire logic                         rst_in,
   // software configuration
   input  aspm_pkg::aspm_cfg_t               cfg_in,
   input  wire logic                         slot_clk_in,
   input  wire logic                         retrain_in,
   input  wire logic [aspm_pkg::NFTS_W-1:0]  nfts_common_in,
   input  wire logic [aspm_pkg::NFTS_W-1:0]  nfts_sep_in,
   input  wire logic [aspm_pkg::LAT_W-1:0]   l1_lat_common_in,
   input  wire logic [aspm_pkg::LAT_W-1:0]   l1_lat_sep_in,
   input  wire logic [aspm_pkg::LAT_W-1:0]   l0s_accept_in,
   input  wire logic [aspm_pkg::LAT_W-1:0]   l1_accept_in,
   // link events
   input  wire logic                         tx_pending_in,
   input  wire logic                         l1_req_in,
   input  wire logic                         l1_ack_in,
   input  wire logic                         l1_nak_in,
   input  wire logic                         partner_exit_in,
   input  wire logic [aspm_pkg::NFTS_W-1:0]  partner_nfts_in,
   input  wire logic                         tx_pll_lock_in,
   input  wire logic                         recovery_done_in,
   // error inputs
   input  wire logic [aspm_pkg::ERR_W-1:0]   err_in,
   input  wire logic [aspm_pkg::ERR_W-1:0]   err_sev_in,
   input  wire logic                         err_sev_wr_in,
   input  wire logic [aspm_pkg::ERR_W-1:0]   err_status_clr_in,
   input  wire logic                         err_class_clr_in,
   // link and phy control
   output aspm_pkg::aspm_state_t             state_out,
   output logic                              tx_elec_idle_out,
   output logic                              rx_enable_out,
   output logic                              tx_allow_out,
   output logic                              fts_send_out,
   output logic      [1:0]                   phy_pd_out,
   // configuration space view
   output aspm_pkg::aspm_lat_t               lat_out,
   output logic                              slot_clk_out,
   // error reporting
   output aspm_pkg::aspm_err_t               err_msg_out,
   output aspm_pkg::aspm_err_t               err_detected_out,
   output logic      [aspm_pkg::ERR_W-1:0]   err_status_out
);
   // fts count to latency code: smallest n with nfts*FTS_NS < LAT_BASE_NS*2^n
   function automatic logic [aspm_pkg::LAT_W-1:0] fts_lat(input logic [aspm_pkg::NFTS_W-1:0] n);
      logic [aspm_pkg::LAT_W-1:0] code;
      int ns;
      code = aspm_pkg::LAT_MAX;
      ns   = int'(n) * aspm_pkg::FTS_NS;
      for (int i = int'(aspm_pkg::LAT_MAX) - 1; i >= 0; i--) begin
         if (ns < (aspm_pkg::LAT_BASE_NS << i)) begin
            code = aspm_pkg::LAT_W'(i);
         end
      end
      return code;
   endfunction

   aspm_pkg::aspm_state_t          st_reg, st_next;
   logic [aspm_pkg::IDLE_W-1:0]    idle_reg, idle_next;
   logic [aspm_pkg::NFTS_W-1:0]    fts_reg, fts_next;
   aspm_pkg::aspm_lat_t            lat_reg, lat_next;
   logic                           load_reg, load_next;
   logic                           txi_reg, txi_next, rxe_reg, rxe_next;
   logic                           txa_reg, txa_next, ftss_reg, ftss_next;
   logic [1:0]                     pd_reg, pd_next;
   logic                           slot_reg;
   logic                           idle_done;

   assign idle_done = (idle_reg == aspm_pkg::IDLE_W'(aspm_pkg::IDLE_CYC));

   // state sequencing runs alone once enables are set
   always_comb begin
      st_next   = st_reg;
      fts_next  = fts_reg;
      idle_next = idle_reg;
      // count idle transmit cycles in L0
      if (st_reg != aspm_pkg::ST_L0 || tx_pending_in) begin
         idle_next = '0;
      end else if (!idle_done) begin
         idle_next = idle_reg + 1'b1;
      end
      unique case (st_reg)
         aspm_pkg::ST_L0: begin
            if (retrain_in) begin
               st_next = aspm_pkg::ST_RECOVERY;
            end else if (cfg_in.l1_en && l1_req_in && !tx_pending_in) begin
               st_next = aspm_pkg::ST_L1_ENTRY;
            end else if (cfg_in.l0s_en && idle_done && !tx_pending_in) begin
               st_next = aspm_pkg::ST_L0S;
            end
         end
         aspm_pkg::ST_L0S: begin
            if (tx_pending_in) begin
               st_next  = aspm_pkg::ST_L0S_EXIT;
               fts_next = partner_nfts_in;
            end
         end
         aspm_pkg::ST_L0S_EXIT: begin
            if (fts_reg <= 1) begin
               st_next = aspm_pkg::ST_L0;
            end else begin
               fts_next = fts_reg - 1'b1;
            end
         end
         aspm_pkg::ST_L1_ENTRY: begin
            if (l1_ack_in) begin
               st_next = aspm_pkg::ST_L1;
            end else if (l1_nak_in) begin
               st_next = aspm_pkg::ST_L0;
            end
         end
         aspm_pkg::ST_L1: begin
            if (tx_pending_in || partner_exit_in) begin
               st_next = aspm_pkg::ST_L1_WAKE;
            end
         end
         aspm_pkg::ST_L1_WAKE: begin
            if (tx_pll_lock_in) begin
               st_next = aspm_pkg::ST_RECOVERY;
            end
         end
         aspm_pkg::ST_RECOVERY: begin
            if (recovery_done_in) begin
               st_next = aspm_pkg::ST_L0;
            end
         end
         default: st_next = aspm_pkg::ST_L0;
      endcase
   end

   // link and phy controls follow the next state
   always_comb begin
      txi_next  = 1'b0;
      rxe_next  = 1'b1;
      txa_next  = 1'b0;
      ftss_next = (st_next == aspm_pkg::ST_L0S_EXIT);
      pd_next   = aspm_pkg::PHY_P0;
      unique case (st_next)
         aspm_pkg::ST_L0:  txa_next = 1'b1;
         aspm_pkg::ST_L0S: begin
            txi_next = 1'b1;
            pd_next  = aspm_pkg::PHY_P0S;
         end
         aspm_pkg::ST_L1: begin
            txi_next = 1'b1;
            rxe_next = 1'b0;
            pd_next  = aspm_pkg::PHY_P1;
         end
         aspm_pkg::ST_L1_WAKE: begin
            txi_next = 1'b1;
            rxe_next = 1'b0;
         end
         default: txa_next = 1'b0;
      endcase
   end

   // latencies load after reset and on each recovery completion
   always_comb begin
      lat_next  = lat_reg;
      load_next = load_reg;
      if (st_reg == aspm_pkg::ST_RECOVERY && recovery_done_in) begin
         load_next = 1'b1;
      end
      if (load_reg) begin
         load_next = 1'b0;
         lat_next.l0s_exit = cfg_in.common_clk ? fts_lat(nfts_common_in)
                                               : fts_lat(nfts_sep_in);
         lat_next.l1_exit  = cfg_in.common_clk ? l1_lat_common_in
                                               : l1_lat_sep_in;
         lat_next.l0s_accept = l0s_accept_in;
         lat_next.l1_accept  = l1_accept_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg   <= aspm_pkg::ST_L0;
         idle_reg <= '0;
         fts_reg  <= '0;
         lat_reg  <= '{aspm_pkg::LAT_RST, aspm_pkg::LAT_RST,
                       aspm_pkg::LAT_RST, aspm_pkg::LAT_RST};
         load_reg <= 1'b1;
         txi_reg  <= 1'b0;
         rxe_reg  <= 1'b1;
         txa_reg  <= 1'b1;
         ftss_reg <= 1'b0;
         pd_reg   <= aspm_pkg::PHY_P0;
         slot_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         idle_reg <= idle_next;
         fts_reg  <= fts_next;
         lat_reg  <= lat_next;
         load_reg <= load_next;
         txi_reg  <= txi_next;
         rxe_reg  <= rxe_next;
         txa_reg  <= txa_next;
         ftss_reg <= ftss_next;
         pd_reg   <= pd_next;
         slot_reg <= slot_clk_in;
      end
   end

   aspm_err_class u_err (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (rst_in),
      .err_in        (err_in),
      .sev_wr_in     (err_sev_in),
      .sev_wr_en_in  (err_sev_wr_in),
      .status_clr_in (err_status_clr_in),
      .class_clr_in  (err_class_clr_in),
      .msg_out       (err_msg_out),
      .detected_out  (err_detected_out),
      .status_out    (err_status_out)
   );

   assign state_out        = st_reg;
   assign tx_elec_idle_out = txi_reg;
   assign rx_enable_out    = rxe_reg;
   assign tx_allow_out     = txa_reg;
   assign fts_send_out     = ftss_reg;
   assign phy_pd_out       = pd_reg;
   assign lat_out          = lat_reg;
   assign slot_clk_out     = slot_reg;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_l1_wake;
      state_out == aspm_pkg::ST_L1_WAKE && tx_pll_lock_in;
   endsequence
   sequence s_recovery;
      state_out == aspm_pkg::ST_RECOVERY;
   endsequence

   l0s_rx_on_a: assert property (state_out == aspm_pkg::ST_L0S
      |-> tx_elec_idle_out && rx_enable_out && phy_pd_out == aspm_pkg::PHY_P0S)
      else $error("L0s must idle tx only");
   l1_quiet_a: assert property (state_out == aspm_pkg::ST_L1
      |-> !rx_enable_out && !tx_allow_out && tx_elec_idle_out)
      else $error("traffic while in L1");
   l1_phy_p1_a: assert property (state_out == aspm_pkg::ST_L1
      |-> phy_pd_out == aspm_pkg::PHY_P1)
      else $error("phy not in P1 during L1");
   l1_exit_path_a: assert property (s_l1_wake |=> s_recovery)
      else $error("L1 wake did not go to recovery");
   recov_to_l0_a: assert property (s_recovery ##0 !recovery_done_in |=> s_recovery)
      else $error("left recovery before negotiation");
   l0s_entry_a: assert property ($rose(state_out == aspm_pkg::ST_L0S)
      |-> $past(cfg_in.l0s_en) && $past(idle_done))
      else $error("L0s entered without enable or idle");
   l0s_auto_exit_a: assert property (state_out == aspm_pkg::ST_L0S && tx_pending_in
      |=> state_out == aspm_pkg::ST_L0S_EXIT ##0 fts_send_out)
      else $error("L0s did not wake on pending traffic");
   l1_lat_sel_a: assert property (load_reg |=> lat_out.l1_exit ==
      ($past(cfg_in.common_clk) ? $past(l1_lat_common_in) : $past(l1_lat_sep_in)))
      else $error("wrong L1 exit latency reported");
   l0s_lat_a: assert property (load_reg && cfg_in.common_clk |=>
      lat_out.l0s_exit == fts_lat($past(nfts_common_in)))
      else $error("wrong L0s exit latency reported");
   accept_lat_a: assert property (load_reg |=> lat_out.l0s_accept == $past(l0s_accept_in)
      && lat_out.l1_accept == $past(l1_accept_in))
      else $error("acceptable latency not held");
   slot_clk_a: assert property (1 |=> slot_clk_out == $past(slot_clk_in))
      else $error("slot clock report stale");
endmodule

// [rtl/aspm_pkg.sv]
// constants, states and carriers for the link power control block
package aspm_pkg;
   // link power states
   typedef enum logic [2:0] {
      ST_L0       = 3'h0,
      ST_L0S      = 3'h1,
      ST_L0S_EXIT = 3'h2,
      ST_L1_ENTRY = 3'h3,
      ST_L1       = 3'h4,
      ST_L1_WAKE  = 3'h5,
      ST_RECOVERY = 3'h6
   } aspm_state_t;

   // phy power-down encodings
   localparam logic [1:0] PHY_P0  = 2'h0;
   localparam logic [1:0] PHY_P0S = 2'h1;
   localparam logic [1:0] PHY_P1  = 2'h2;

   // timing
   localparam int CLK_NS       = 25;
   localparam int IDLE_NS      = 1000;
   localparam int IDLE_CYC     = (IDLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int IDLE_W       = 6;
   localparam int FTS_NS       = 16;
   localparam int LAT_BASE_NS  = 64;

   // latency field and fts count widths
   localparam int LAT_W = 3;
   localparam int NFTS_W = 8;
   localparam logic [LAT_W-1:0] LAT_MAX = 3'h7;
   localparam logic [LAT_W-1:0] LAT_RST = 3'h0;

   // error sources
   localparam int ERR_W = 10;
   localparam int E_RX_PORT   = 0;
   localparam int E_BAD_TLP   = 1;
   localparam int E_BAD_DLLP  = 2;
   localparam int E_REPLAY_TO = 3;
   localparam int E_REPLAY_RO = 4;
   localparam int E_DLL_PROTO = 5;
   localparam int E_TRAINING  = 6;
   localparam int E_POISONED  = 7;
   localparam int E_ECRC      = 8;
   localparam int E_UNSUP     = 9;
   // sources handled by hardware
   localparam logic [ERR_W-1:0] ERR_COR_MASK = 10'h01f;
   // default uncorrectable severity, 1 = fatal
   localparam logic [ERR_W-1:0] ERR_SEV_RST  = 10'h060;

   // software power configuration
   typedef struct packed {
      logic l0s_en;
      logic l1_en;
      logic common_clk;
   } aspm_cfg_t;

   // latencies presented in configuration space
   typedef struct packed {
      logic [LAT_W-1:0] l0s_exit;
      logic [LAT_W-1:0] l1_exit;
      logic [LAT_W-1:0] l0s_accept;
      logic [LAT_W-1:0] l1_accept;
   } aspm_lat_t;

   // per-class error reporting
   typedef struct packed {
      logic cor;
      logic nonfatal;
      logic fatal;
   } aspm_err_t;
endpackage

// [tb/aspm_link_pm_tb.sv]
// self-checking bench for the link power control block
module aspm_link_pm_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  sys_clk_in = 1'b0;
   logic                  rst_in = 1'b1;
   aspm_pkg::aspm_cfg_t   cfg = 3'h0;
   logic                  slot_clk = 1'b0, retrain = 1'b0, tx_pend = 1'b1, l1_req = 1'b0;
   logic                  nak = 1'b0, wake = 1'b0, sev_wr = 1'b0, cls_clr = 1'b0;
   logic [3:0]            dly = 4'h1;
   logic [7:0]            nfts = 8'h03;
   logic [2:0]            acc0 = 3'h5, acc1 = 3'h6;
   logic [9:0]            err = 10'h0, sev = 10'h0, st_clr = 10'h0;
   logic                  ack, nk, pexit, lock, rdone, tx_idle, rx_en, tx_ok, fts, slot_o;
   logic [7:0]            pnfts;
   logic [1:0]            pd;
   logic [9:0]            st;
   aspm_pkg::aspm_state_t state;
   aspm_pkg::aspm_lat_t   lat;
   aspm_pkg::aspm_err_t   msg, det;
   int                    num_errors = 0, checks = 0, n;

   always #12.5 sys_clk_in = ~sys_clk_in;

   aspm_link_pm dut_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cfg_in(cfg), .slot_clk_in(slot_clk),
      .retrain_in(retrain), .nfts_common_in(8'h03), .nfts_sep_in(8'h14),
      .l1_lat_common_in(3'h2), .l1_lat_sep_in(3'h5), .l0s_accept_in(acc0),
      .l1_accept_in(acc1), .tx_pending_in(tx_pend), .l1_req_in(l1_req), .l1_ack_in(ack),
      .l1_nak_in(nk), .partner_exit_in(pexit), .partner_nfts_in(pnfts),
      .tx_pll_lock_in(lock), .recovery_done_in(rdone), .err_in(err), .err_sev_in(sev),
      .err_sev_wr_in(sev_wr), .err_status_clr_in(st_clr), .err_class_clr_in(cls_clr),
      .state_out(state), .tx_elec_idle_out(tx_idle), .rx_enable_out(rx_en),
      .tx_allow_out(tx_ok), .fts_send_out(fts), .phy_pd_out(pd), .lat_out(lat),
      .slot_clk_out(slot_o), .err_msg_out(msg), .err_detected_out(det),
      .err_status_out(st));

   aspm_partner_model partner_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .state_in(state), .nak_in(nak),
      .wake_in(wake), .dly_in(dly), .nfts_in(nfts), .l1_ack_out(ack), .l1_nak_out(nk),
      .exit_out(pexit), .nfts_out(pnfts), .pll_lock_out(lock), .rec_done_out(rdone));

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_st(input aspm_pkg::aspm_state_t s, output int k);
      k = 0;
      while (state !== s && k < 300) begin
         tick(1);
         k++;
      end
      if (k >= 300) begin
         num_errors++;
         $display("[FAIL] t=%0t state wait ran out", $time);
         print_verdict();
      end
   endtask

   // l0s exit code: smallest n with nfts*16ns below 64ns*2^n
   function automatic logic [2:0] l0s_code(input logic [7:0] v);
      for (int i = 0; i < 7; i++)
         if (v * 16 < (64 << i)) return i[2:0];
      return 3'h7;
   endfunction

   initial begin
      tick(5);
      check({state, tx_idle, rx_en, tx_ok, fts, pd}, 9'h018);
      check({lat, msg, det, st}, 16'h0);
      tick(1);
      rst_in = 1'b0;
      tick(2);
      check(lat, {l0s_code(8'h14), 3'h5, 3'h5, 3'h6});
      slot_clk = 1'b1;
      tick(1);
      check(slot_o, 1'b1);
      for (int i = 0; i < 10; i++) begin
         err = 10'h001 << i;
         tick(1);
         err = 10'h0;
         check(msg, {aspm_pkg::ERR_COR_MASK[i], !aspm_pkg::ERR_COR_MASK[i] &&
                     !aspm_pkg::ERR_SEV_RST[i], !aspm_pkg::ERR_COR_MASK[i] &&
                     aspm_pkg::ERR_SEV_RST[i]});
         tick(1);
         check(msg, 3'h0);
      end
      check({det, st}, 13'h1fff);
      st_clr = 10'h3ff;
      cls_clr = 1'b1;
      tick(1);
      st_clr = 10'h0;
      cls_clr = 1'b0;
      sev = 10'h080;
      sev_wr = 1'b1;
      tick(1);
      sev_wr = 1'b0;
      check({det, st}, 13'h0);
      err = 10'h0c0;
      tick(1);
      err = 10'h0;
      check({msg, st}, {3'h3, 10'h0c0});
      l1_req = 1'b1;
      tick(5);
      check(state, aspm_pkg::ST_L0);
      cfg.l1_en = 1'b1;
      tick(5);
      check(state, aspm_pkg::ST_L0);
      nak = 1'b1;
      tx_pend = 1'b0;
      wait_st(aspm_pkg::ST_L1_ENTRY, n);
      wait_st(aspm_pkg::ST_L0, n);
      nak = 1'b0;
      wait_st(aspm_pkg::ST_L1, n);
      l1_req = 1'b0;
      check({pd, tx_ok, rx_en}, {aspm_pkg::PHY_P1, 2'h0});
      tick(5);
      check(state, aspm_pkg::ST_L1);
      dly = 4'h8;
      wake = 1'b1;
      wait_st(aspm_pkg::ST_L1_WAKE, n);
      tick(4);
      check(state, aspm_pkg::ST_L1_WAKE);
      wait_st(aspm_pkg::ST_RECOVERY, n);
      wait_st(aspm_pkg::ST_L0, n);
      wake = 1'b0;
      tx_pend = 1'b1;
      dly = 4'h1;
      tick(3);
      check(lat, {3'h3, 3'h5, 3'h5, 3'h6});
      cfg.common_clk = 1'b1;
      acc0 = 3'h0;
      acc1 = 3'h0;
      retrain = 1'b1;
      tick(1);
      retrain = 1'b0;
      wait_st(aspm_pkg::ST_RECOVERY, n);
      wait_st(aspm_pkg::ST_L0, n);
      tick(3);
      check(lat, {l0s_code(8'h03), 3'h2, 3'h0, 3'h0});
      cfg.l0s_en = 1'b1;
      for (int k = 0; k < 2; k++) begin
         nfts = k ? 8'h05 : 8'h00;
         tick(1);
         tx_pend = 1'b0;
         wait_st(aspm_pkg::ST_L0S, n);
         check(n >= 40 && n <= 42, 1'b1);
         check({tx_idle, rx_en, pd}, {2'h3, aspm_pkg::PHY_P0S});
         tx_pend = 1'b1;
         wait_st(aspm_pkg::ST_L0S_EXIT, n);
         n = 0;
         while (state === aspm_pkg::ST_L0S_EXIT && n < 300) begin
            check(fts, 1'b1);
            tick(1);
            n++;
         end
         check(16'(n), k ? 16'h5 : 16'h1);
         check({state, tx_ok, fts}, {aspm_pkg::ST_L0, 2'h2});
      end
      print_verdict();
   end
endmodule

// [tb/aspm_partner_model.sv]
// link partner model answering the power-state handshakes
module aspm_partner_model (
   // clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   // device state and scenario controls
   input  aspm_pkg::aspm_state_t state_in,
   input  wire logic             nak_in,
   input  wire logic             wake_in,
   input  wire logic [3:0]       dly_in,
   input  wire logic [7:0]       nfts_in,
   // answers to the device
   output logic                  l1_ack_out,
   output logic                  l1_nak_out,
   output logic                  exit_out,
   output logic [7:0]            nfts_out,
   output logic                  pll_lock_out,
   output logic                  rec_done_out
);
   timeunit 1ns;
   timeprecision 100ps;
   aspm_pkg::aspm_state_t prev_reg;
   logic [3:0]            cnt_reg;
   logic [3:0]            cnt_next;
   logic [4:0]            ans_reg;
   logic [4:0]            ans_next;
   logic                  late;
   assign nfts_out = nfts_in;
   assign {l1_ack_out, l1_nak_out, exit_out, pll_lock_out, rec_done_out} = ans_reg;
   always_comb begin
      // count left over from the previous state must not count here
      late = (state_in == prev_reg) && (cnt_reg >= dly_in);
      cnt_next = (state_in != prev_reg) ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hf};
      ans_next[4] = state_in == aspm_pkg::ST_L1_ENTRY && !nak_in && late;
      ans_next[3] = state_in == aspm_pkg::ST_L1_ENTRY && nak_in && late;
      ans_next[2] = state_in == aspm_pkg::ST_L1 && wake_in;
      // pll off in L1, relocks only after the chosen delay
      ans_next[1] = !(state_in == aspm_pkg::ST_L1 ||
                      (state_in == aspm_pkg::ST_L1_WAKE && !late));
      ans_next[0] = state_in == aspm_pkg::ST_RECOVERY && late;
   end
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_reg <= aspm_pkg::ST_L0;
         cnt_reg  <= 4'h0;
         ans_reg  <= 5'h02;
      end else begin
         prev_reg <= state_in;
         cnt_reg  <= cnt_next;
         ans_reg  <= ans_next;
      end
   end
endmodule
